// >>> rtl/blk_mon_pkg.sv
// Constants shared by the block-interrupt counter and the program-counter monitor.
// Assumes a 16-bit register port with word offsets and a 24-bit core program counter.
package blk_mon_pkg;

  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned PC_W    = 24;
  localparam int unsigned PC_LO_W = 16;
  localparam int unsigned PC_HI_W = 8;
  localparam int unsigned LEN_W   = 16;

  // Register offsets, one 16-bit word each
  localparam logic [ADDR_W-1:0] ADDR_BLOCK_IRQ_ENABLE  = 16'hf450;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK_LENGTH      = 16'hf451;
  localparam logic [ADDR_W-1:0] ADDR_PC_UPPER          = 16'hf460;
  localparam logic [ADDR_W-1:0] ADDR_PC_LOWER          = 16'hf461;
  localparam logic [ADDR_W-1:0] ADDR_PC_FREEZE_CLEAR   = 16'hf462;
  localparam logic [ADDR_W-1:0] ADDR_FRAME_PEAK_UPPER  = 16'hf463;
  localparam logic [ADDR_W-1:0] ADDR_FRAME_PEAK_LOWER  = 16'hf464;
  localparam logic [ADDR_W-1:0] ADDR_ALLTIME_PEAK_UPPER = 16'hf465;
  localparam logic [ADDR_W-1:0] ADDR_ALLTIME_PEAK_LOWER = 16'hf466;

  // Field positions
  localparam int unsigned BLOCK_IRQ_ENABLE_BIT = 0;
  localparam int unsigned PC_FREEZE_CLEAR_BIT  = 0;
  localparam int unsigned PC_UPPER_LSB         = 16;

  // Reset values and the count step
  localparam logic [DATA_W-1:0] WORD_RESET      = 16'h0000;
  localparam logic [LEN_W-1:0]  BLOCK_LEN_RESET = 16'h0000;
  localparam logic [PC_W-1:0]   PC_RESET        = 24'h000000;
  localparam logic [LEN_W-1:0]  COUNT_STEP      = 16'h0001;

  // Clear control: running or held cleared
  typedef enum logic [0:0] {
    CLR_RUN,
    CLR_HELD
  } clear_state_e;

endpackage

// >>> rtl/block_counter.sv
// Block counter: counts frame-start pulses and pulses when the block length is reached.
// Assumes frame_start_in is a one-cycle pulse from logic on sys_clk_in.
`timescale 1ns/1ps
module block_counter (
  input  wire logic                          sys_clk_in,
  input  wire logic                          resetn_in,
  input  wire logic                          clk_en_in,
  input  wire logic                          enable_in,
  input  wire logic                          frame_start_in,
  input  wire logic [blk_mon_pkg::LEN_W-1:0] length_in,
  output logic                               block_irq_out,
  output logic [blk_mon_pkg::LEN_W-1:0]      count_out
);

  typedef struct packed {
    logic [blk_mon_pkg::LEN_W-1:0] count;
    logic                          irq;
  } cnt_state_s;

  cnt_state_s                    state_q;
  cnt_state_s                    state_d;
  logic [blk_mon_pkg::LEN_W-1:0] count_next;

  always_comb begin
    state_d     = state_q;
    state_d.irq = 1'b0;
    count_next  = blk_mon_pkg::LEN_W'(state_q.count + blk_mon_pkg::COUNT_STEP);
    if (!enable_in) begin
      state_d.count = blk_mon_pkg::BLOCK_LEN_RESET;
    end else if (frame_start_in) begin
      if (count_next == length_in) begin
        state_d.irq   = 1'b1;
        state_d.count = blk_mon_pkg::BLOCK_LEN_RESET;
      end else begin
        state_d.count = count_next;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= '0;
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  assign block_irq_out = state_q.irq;
  assign count_out     = state_q.count;

endmodule

// >>> rtl/pc_peak_tracker.sv
// Program-counter peak tracker: running peak, last frame or block peak, all-time peak.
// Assumes pc_in is the monitor's held program counter, already zero while cleared.
`timescale 1ns/1ps
module pc_peak_tracker (
  input  wire logic                         sys_clk_in,
  input  wire logic                         resetn_in,
  input  wire logic                         clk_en_in,
  input  wire logic [blk_mon_pkg::PC_W-1:0] pc_in,
  input  wire logic                         boundary_in,
  input  wire logic                         clear_in,
  input  wire logic                         alltime_reset_in,
  output logic [blk_mon_pkg::PC_W-1:0]      frame_peak_out,
  output logic [blk_mon_pkg::PC_W-1:0]      alltime_peak_out
);

  typedef struct packed {
    logic [blk_mon_pkg::PC_W-1:0] run_peak;
    logic [blk_mon_pkg::PC_W-1:0] frame_peak;
    logic [blk_mon_pkg::PC_W-1:0] alltime;
  } peak_state_s;

  peak_state_s                  state_q;
  peak_state_s                  state_d;
  logic [blk_mon_pkg::PC_W-1:0] run_max;

  always_comb begin
    state_d = state_q;
    run_max = (pc_in > state_q.run_peak) ? pc_in : state_q.run_peak;
    if (clear_in) begin
      state_d.run_peak   = blk_mon_pkg::PC_RESET;
      state_d.frame_peak = blk_mon_pkg::PC_RESET;
    end else if (boundary_in) begin
      state_d.frame_peak = run_max;
      state_d.run_peak   = pc_in;
    end else begin
      state_d.run_peak = run_max;
    end
    if (alltime_reset_in) begin
      state_d.alltime = blk_mon_pkg::PC_RESET;
    end else if (!clear_in && run_max > state_q.alltime) begin
      state_d.alltime = run_max;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= '0;
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  assign frame_peak_out   = state_q.frame_peak;
  assign alltime_peak_out = state_q.alltime;

endmodule

// >>> rtl/block_irq_and_pc_monitor.sv
// Block-interrupt generator and program-counter monitor with its register port.
// Assumes frame_start_in and pc_value_in come from core logic on sys_clk_in.
//
// What this block does
// - Block interrupts only while enable bit is 1
// - Frame-start pulse advances the block counter
// - Count equals length: interrupt, counter restarts
// - Block length is 16-bit read-write, resets zero
// - Live program counter readable, upper and lower
// - Clear bit holds counter zero, frozen
// - Clear then release resets all-time maximum
// - Record peak of last frame or block
// - Clear control also clears last-frame peak
// - Record highest peak since core started
// - Peak records 24-bit read-only, split, reset zero
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module block_irq_and_pc_monitor (
  input  wire logic                           sys_clk_in,
  input  wire logic                           resetn_in,
  input  wire logic                           clk_en_in,
  input  wire logic                           frame_start_in,
  input  wire logic [blk_mon_pkg::PC_W-1:0]   pc_value_in,
  input  wire logic [blk_mon_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [blk_mon_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                           wr_in,
  input  wire logic                           rd_in,
  output logic [blk_mon_pkg::DATA_W-1:0]      rdata_out,
  output logic                                block_irq_out,
  output logic                                boundary_out,
  output logic                                pc_freeze_out
);

  typedef struct packed {
    logic                             irq_enable;
    logic [blk_mon_pkg::LEN_W-1:0]    block_length;
    logic                             clear;
    blk_mon_pkg::clear_state_e        clr_state;
    logic                             alltime_reset;
    logic [blk_mon_pkg::PC_W-1:0]     pc;
    logic [blk_mon_pkg::DATA_W-1:0]   rdata;
    logic                             irq;
    logic                             boundary;
  } mon_state_s;

  mon_state_s                     state_q;
  mon_state_s                     state_d;
  logic                           cnt_irq;
  logic [blk_mon_pkg::LEN_W-1:0]  cnt_value;
  logic [blk_mon_pkg::PC_W-1:0]   frame_peak;
  logic [blk_mon_pkg::PC_W-1:0]   alltime_peak;
  logic                           boundary;
  logic                           wr_enable;
  logic                           wr_length;
  logic                           wr_clear;
  logic [blk_mon_pkg::DATA_W-1:0] read_word;

  // Frame boundary normally, block boundary once block interrupts are on
  assign boundary = state_q.irq_enable ? cnt_irq : frame_start_in;

  block_counter u_block_counter (
    .sys_clk_in     (sys_clk_in),
    .resetn_in      (resetn_in),
    .clk_en_in      (clk_en_in),
    .enable_in      (state_q.irq_enable),
    .frame_start_in (frame_start_in),
    .length_in      (state_q.block_length),
    .block_irq_out  (cnt_irq),
    .count_out      (cnt_value)
  );

  pc_peak_tracker u_pc_peak_tracker (
    .sys_clk_in       (sys_clk_in),
    .resetn_in        (resetn_in),
    .clk_en_in        (clk_en_in),
    .pc_in            (state_q.pc),
    .boundary_in      (boundary),
    .clear_in         (state_q.clear),
    .alltime_reset_in (state_q.alltime_reset),
    .frame_peak_out   (frame_peak),
    .alltime_peak_out (alltime_peak)
  );

  assign wr_enable = wr_in && (addr_in == blk_mon_pkg::ADDR_BLOCK_IRQ_ENABLE);
  assign wr_length = wr_in && (addr_in == blk_mon_pkg::ADDR_BLOCK_LENGTH);
  assign wr_clear  = wr_in && (addr_in == blk_mon_pkg::ADDR_PC_FREEZE_CLEAR);

  // Read mux; reserved bits and unmapped offsets read as zero
  always_comb begin
    read_word = blk_mon_pkg::WORD_RESET;
    case (addr_in)
      blk_mon_pkg::ADDR_BLOCK_IRQ_ENABLE: begin
        read_word[blk_mon_pkg::BLOCK_IRQ_ENABLE_BIT] = state_q.irq_enable;
      end
      blk_mon_pkg::ADDR_BLOCK_LENGTH: begin
        read_word = state_q.block_length;
      end
      blk_mon_pkg::ADDR_PC_UPPER: begin
        read_word[blk_mon_pkg::PC_HI_W-1:0] =
          state_q.pc[blk_mon_pkg::PC_W-1:blk_mon_pkg::PC_UPPER_LSB];
      end
      blk_mon_pkg::ADDR_PC_LOWER: begin
        read_word = state_q.pc[blk_mon_pkg::PC_LO_W-1:0];
      end
      blk_mon_pkg::ADDR_PC_FREEZE_CLEAR: begin
        read_word[blk_mon_pkg::PC_FREEZE_CLEAR_BIT] = state_q.clear;
      end
      blk_mon_pkg::ADDR_FRAME_PEAK_UPPER: begin
        read_word[blk_mon_pkg::PC_HI_W-1:0] =
          frame_peak[blk_mon_pkg::PC_W-1:blk_mon_pkg::PC_UPPER_LSB];
      end
      blk_mon_pkg::ADDR_FRAME_PEAK_LOWER: begin
        read_word = frame_peak[blk_mon_pkg::PC_LO_W-1:0];
      end
      blk_mon_pkg::ADDR_ALLTIME_PEAK_UPPER: begin
        read_word[blk_mon_pkg::PC_HI_W-1:0] =
          alltime_peak[blk_mon_pkg::PC_W-1:blk_mon_pkg::PC_UPPER_LSB];
      end
      blk_mon_pkg::ADDR_ALLTIME_PEAK_LOWER: begin
        read_word = alltime_peak[blk_mon_pkg::PC_LO_W-1:0];
      end
      default: begin
        read_word = blk_mon_pkg::WORD_RESET;
      end
    endcase
  end

  always_comb begin
    state_d               = state_q;
    state_d.alltime_reset = 1'b0;

    // Register writes
    if (wr_enable) begin
      state_d.irq_enable = wdata_in[blk_mon_pkg::BLOCK_IRQ_ENABLE_BIT];
    end
    if (wr_length) begin
      state_d.block_length = wdata_in;
    end
    if (wr_clear) begin
      state_d.clear = wdata_in[blk_mon_pkg::PC_FREEZE_CLEAR_BIT];
    end

    // Clear control: a release after a hold resets the all-time record
    unique case (state_q.clr_state)
      blk_mon_pkg::CLR_RUN: begin
        if (state_q.clear) begin
          state_d.clr_state = blk_mon_pkg::CLR_HELD;
        end
      end
      blk_mon_pkg::CLR_HELD: begin
        if (!state_q.clear) begin
          state_d.clr_state     = blk_mon_pkg::CLR_RUN;
          state_d.alltime_reset = 1'b1;
        end
      end
    endcase

    // Program counter: held at zero while clear is set
    if (state_q.clear) begin
      state_d.pc = blk_mon_pkg::PC_RESET;
    end else begin
      state_d.pc = pc_value_in;
    end

    // Read data stands only in the cycle after the read strobe
    state_d.rdata = rd_in ? read_word : blk_mon_pkg::WORD_RESET;

    state_d.irq      = cnt_irq && state_q.irq_enable;
    state_d.boundary = boundary;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= '0;
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  assign rdata_out     = state_q.rdata;
  assign block_irq_out = state_q.irq;
  assign boundary_out  = state_q.boundary;
  assign pc_freeze_out = state_q.clear;

endmodule

// >>> sim/core_seq_model.sv
// Core sequencer model: the program counter ramps up from base_in each frame, with a frame-start pulse in the cycle of its last step.
// Assumes the bench holds run_in low between scenarios, so the counter rests at base_in.
`timescale 1ns/1ps
module core_seq_model (
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        run_in,
  input  wire logic [23:0] base_in,
  output logic             frame_start_out,
  output logic [23:0]      pc_out
);
  localparam logic [7:0] FRAME_LEN = 8'h05;
  logic [7:0] step_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      step_q <= 8'h00;
      frame_start_out <= 1'b0;
      pc_out <= 24'h000000;
    end else begin
      pc_out <= base_in + 24'(step_q);
      frame_start_out <= run_in && step_q == FRAME_LEN;
      step_q <= (!run_in || step_q == FRAME_LEN) ? 8'h00 : step_q + 8'h01;
    end
  end
endmodule

// >>> sim/block_irq_and_pc_monitor_properties.sv
// Port checker for the block-interrupt and program-counter monitor.
// Assumes clk_en_in is held high and the two strobes never rise together.
`timescale 1ns/1ps
module blk_mon_checker (
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  input wire logic        frame_start_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        block_irq_out,
  input wire logic        boundary_out,
  input wire logic        pc_freeze_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic en_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in) en_q <= 1'b0;
    else if (wr_in && addr_in == blk_mon_pkg::ADDR_BLOCK_IRQ_ENABLE) en_q <= wdata_in[0];
  sequence s_wr(a); wr_in && addr_in == a; endsequence
  sequence s_rd(a); rd_in && addr_in == a; endsequence
  property p_en_back;
    s_wr(16'hf450) ##2 s_rd(16'hf450) |=> rdata_out == {15'h0000, $past(wdata_in[0], 3)};
  endproperty
  property p_len_back; s_wr(16'hf451) ##2 s_rd(16'hf451) |=> rdata_out == $past(wdata_in, 3); endproperty
  property p_idle_zero; !$past(rd_in) |-> rdata_out == 16'h0000; endproperty
  property p_irq_cause; block_irq_out |-> $past(frame_start_in, 2) && $past(en_q, 2); endproperty
  property p_bnd_frame; frame_start_in && !en_q |=> boundary_out; endproperty
  property p_bnd_block; $past(en_q, 2) && $past(en_q) |-> boundary_out == block_irq_out; endproperty
  property p_freeze; s_wr(16'hf462) |=> pc_freeze_out == $past(wdata_in[0]); endproperty
  property p_frozen_pc;
    rd_in && addr_in == 16'hf461 && pc_freeze_out && $past(pc_freeze_out) |=> rdata_out == 16'h0000;
  endproperty
  property p_upper_rsvd; rd_in && addr_in inside {16'hf460, 16'hf463, 16'hf465} |=> rdata_out[15:8] == 8'h00; endproperty
  property p_unmapped;
    rd_in && !(addr_in inside {[16'hf450:16'hf451], [16'hf460:16'hf466]}) |=> rdata_out == 16'h0000;
  endproperty
  a_en_back: assert property (p_en_back) else $error("enable readback wrong");
  a_len_back: assert property (p_len_back) else $error("length readback wrong");
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside answer cycle");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled frame start");
  a_bnd_frame: assert property (p_bnd_frame) else $error("no frame boundary");
  a_bnd_block: assert property (p_bnd_block) else $error("boundary not block interrupt");
  a_freeze: assert property (p_freeze) else $error("freeze output wrong");
  a_frozen_pc: assert property (p_frozen_pc) else $error("frozen counter not zero");
  a_upper_rsvd: assert property (p_upper_rsvd) else $error("upper byte reserved bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind block_irq_and_pc_monitor blk_mon_checker chk_u (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .frame_start_in(frame_start_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .block_irq_out(block_irq_out),
  .boundary_out(boundary_out), .pc_freeze_out(pc_freeze_out));

// >>> sim/test_block_irq_and_pc_monitor.sv
// Self-checking bench for the block-interrupt and program-counter monitor.
// Assumes core_seq_model drives frame starts and the program counter.
`timescale 1ns/1ps
module test_block_irq_and_pc_monitor;
  logic        sys_clk_in = 1'b0;
  logic        resetn_in  = 1'b0;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic        run        = 1'b0;
  logic        clk_en     = 1'b1;
  logic        rd_seen    = 1'b0;
  logic [15:0] addr_in    = 16'h0000;
  logic [15:0] wdata_in   = 16'h0000;
  logic [23:0] base       = 24'h000000;
  logic [23:0] pc_value_in, p1, p2;
  logic [15:0] rdata_out, len;
  logic        frame_start_in, block_irq_out, boundary_out, pc_freeze_out;
  logic [15:0] expq[$];
  logic [15:0] amap[10] = '{16'hf450, 16'hf451, 16'hf460, 16'hf461, 16'hf462, 16'hf463, 16'hf464,
                            16'hf465, 16'hf466, 16'hf455};
  logic [15:0] lens[3]  = '{16'h0001, 16'h0002, 16'h0003};
  int          fail_count = 0, n_compared = 0, fs_cnt = 0, irq_cnt = 0, bnd_cnt = 0, f0, i0, b0;
  always #25 sys_clk_in = ~sys_clk_in;
  block_irq_and_pc_monitor dut_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en),
    .frame_start_in(frame_start_in), .pc_value_in(pc_value_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .block_irq_out(block_irq_out),
    .boundary_out(boundary_out), .pc_freeze_out(pc_freeze_out));
  core_seq_model core_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .run_in(run), .base_in(base),
    .frame_start_out(frame_start_in), .pc_out(pc_value_in));
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    if (rd_seen) chk("rdata", {8'h00, rdata_out}, {8'h00, expq.pop_front()});
    rd_seen <= rd_in;
    fs_cnt  <= fs_cnt + int'(frame_start_in);
    irq_cnt <= irq_cnt + int'(block_irq_out);
    bnd_cnt <= bnd_cnt + int'(boundary_out);
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    expq.push_back(e);
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
  endtask
  task automatic rd24(input logic [15:0] a, input logic [23:0] v);
    rd(a - 16'h0001, {8'h00, v[23:16]});
    rd(a, v[15:0]);
  endtask
  task automatic run_frames(input int n);
    f0 = fs_cnt;
    i0 = irq_cnt;
    b0 = bnd_cnt;
    run <= 1'b1;
    repeat (n) @(posedge sys_clk_in);
    run <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
  endtask
  initial begin
    void'($urandom(32'h7fa9));
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    foreach (amap[k]) rd(amap[k], 16'h0000);
    wr(16'hf450, 16'hffff);
    rd(16'hf450, 16'h0001);
    len = 16'($urandom);
    wr(16'hf451, len);
    rd(16'hf451, len);
    // Clock enable low: a write is not taken
    repeat (2) @(posedge sys_clk_in);
    clk_en <= 1'b0;
    wr(16'hf451, ~len);
    clk_en <= 1'b1;
    @(posedge sys_clk_in);
    rd(16'hf451, len);
    wr(16'hf461, 16'($urandom));
    rd(16'hf461, 16'h0000);
    foreach (lens[k]) begin
      wr(16'hf450, 16'h0000);
      wr(16'hf451, lens[k]);
      wr(16'hf450, 16'h0001);
      run_frames(62);
      chk("irq", 24'(irq_cnt - i0), 24'((fs_cnt - f0) / int'(lens[k])));
      chk("bnd", 24'(bnd_cnt - b0), 24'((fs_cnt - f0) / int'(lens[k])));
    end
    wr(16'hf450, 16'h0000);
    p1 = 24'($urandom) & 24'h7fffff;
    base <= p1;
    run_frames(40);
    chk("irq_off", 24'(irq_cnt - i0), 24'h000000);
    chk("bnd_off", 24'(bnd_cnt - b0), 24'(fs_cnt - f0));
    rd24(16'hf461, p1);
    rd24(16'hf464, p1 + 24'h000005);
    rd24(16'hf466, p1 + 24'h000005);
    p2 = p1 >> 1;
    base <= p2;
    run_frames(40);
    rd24(16'hf464, p2 + 24'h000005);
    rd24(16'hf466, p1 + 24'h000005);
    base <= 24'h000000;
    wr(16'hf462, 16'h0001);
    repeat (2) @(posedge sys_clk_in);
    rd24(16'hf461, 24'h000000);
    rd24(16'hf464, 24'h000000);
    rd24(16'hf466, p1 + 24'h000005);
    rd(16'hf462, 16'h0001);
    chk("freeze", {23'h000000, pc_freeze_out}, 24'h000001);
    wr(16'hf462, 16'h0000);
    repeat (3) @(posedge sys_clk_in);
    chk("freeze", {23'h000000, pc_freeze_out}, 24'h000000);
    rd24(16'hf466, 24'h000000);
    repeat (3) @(posedge sys_clk_in);
    give_verdict();
  end
  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end
endmodule
